// ==== rtl/ddslc_top.sv ====
// Contract
// - shift in on falling clock while sync low
// - shift register contents go out serially
// - clear falling edge zeroes both converter registers
// - strobe low: update addressed output at sync rise
// - strobe high: input only, strobe fall loads all
// - two pins configurable, readable, inputs pulled up
// - reset output follows supply monitor
// - clamp input low zeroes outputs, keeps registers
// - coding select picks offset binary or twos
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo, width and depth shape the storage
module ddslc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW:0] wr_q; // write pointer with wrap bit
  logic [AW:0] rd_q; // read pointer with wrap bit
  logic full;
  logic empty;
  logic push;
  logic pop;

  // wrap bit differs and index equal means full
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_q[AW-1:0]];

  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule : ddslc_fifo

////////////////////////////////////////////////////////////////////////////////
module ddslc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  input wire logic zero_clear_n,
  input wire logic output_load_strobe_n,
  input wire logic output_clamp_in,
  input wire logic coding_select,
  input wire logic supply_good,
  input wire logic gp_pin_zero_i,
  output logic gp_pin_zero_o,
  output logic gp_pin_zero_oe,
  output logic gp_pin_zero_pu,
  input wire logic gp_pin_one_i,
  output logic gp_pin_one_o,
  output logic gp_pin_one_oe,
  output logic gp_pin_one_pu,
  output logic monitor_reset_out,
  output ddslc_pkg::ddslc_dac_t dac_code
);
  import ddslc_pkg::*;

  // straight binary code for the analog core
  function automatic logic [15:0] to_straight(input logic [15:0] code,
                                              input logic offset_bin);
    to_straight = offset_bin ? code : (code ^ MSB_FLIP);
  endfunction : to_straight

  //////////////////////////////////////////////////////////////////////////////
  // link domain, clocked by the host's shift clock
  logic [4:0] bit_cnt_q; // bits taken in current word
  logic first_q; // no falling edge seen yet in frame
  logic [23:0] sr_q; // serial shift register
  logic spill_q; // bit pushed out of the top
  logic sdo_q; // serial output flop
  logic [23:0] xfer_q; // complete word for mclk side
  logic word_tgl_q; // flips once per complete word

  // mclk-side readback, held while the frame sync is low
  ddslc_word_t rb_q;
  logic rb_vld_q;

  // count restarts whenever sync goes high; no edge is needed for that
  always_ff @(negedge shift_clk or posedge frame_sync_n or posedge rst)
  begin
    if (rst)
      bit_cnt_q <= BIT_FIRST; // known count even if sync never rose
    else if (frame_sync_n)
      bit_cnt_q <= BIT_FIRST;
    else if (bit_cnt_q == BIT_LAST)
      bit_cnt_q <= BIT_FIRST; // chained words repeat every 24
    else
      bit_cnt_q <= bit_cnt_q + BIT_STEP;
  end

  // first edge marker, set again by each frame end
  always_ff @(negedge shift_clk or posedge frame_sync_n or posedge rst)
  begin
    if (rst)
      first_q <= 1'b1;
    else if (frame_sync_n)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  // capture on the falling edge, only inside a frame
  always_ff @(negedge shift_clk or posedge rst)
  begin
    if (rst)
    begin
      sr_q <= WORD_RESET;
      spill_q <= 1'b0;
    end
    else if (!frame_sync_n)
    begin
      if (first_q && rb_vld_q)
      begin
        // readback word is quasi-static here: changed only while sync high
        sr_q <= {rb_q[22:0], serial_in_line};
        spill_q <= rb_q[23];
      end
      else
      begin
        sr_q <= {sr_q[22:0], serial_in_line};
        spill_q <= sr_q[23];
      end
    end
  end

  // hand a word across each time 24 bits are in
  always_ff @(negedge shift_clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_q <= WORD_RESET;
      word_tgl_q <= 1'b0;
    end
    else if (!frame_sync_n && bit_cnt_q == BIT_LAST)
    begin
      xfer_q <= {sr_q[22:0], serial_in_line};
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // output changes on the rising edge, half a period before sampling
  always_ff @(posedge shift_clk or posedge rst)
  begin
    if (rst)
      sdo_q <= 1'b0;
    else if (!frame_sync_n)
      sdo_q <= spill_q;
  end

  assign serial_out_line = sdo_q;

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin read in the mclk domain and the word toggle
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] meta_q; // first stage, read only by sync_q
  logic [SYNC_W-1:0] sync_q; // safe levels
  logic frm_d1_q; // sync delayed once
  logic frm_d2_q; // sync delayed twice
  logic tgl_prev_q;
  logic clr_prev_q;
  logic output_load_strobe_n_prev_q;

  assign async_in = {gp_pin_one_i, gp_pin_zero_i, supply_good, coding_select,
                     output_clamp_in, output_load_strobe_n, zero_clear_n,
                     word_tgl_q, frame_sync_n};

  // synchroniser chain, free running through reset so levels are true at release
  always_ff @(posedge mclk)
  begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  // history for edge detection, taken from the second stage only
  // also free running: a fixed reset value would fake an edge after release
  always_ff @(posedge mclk)
  begin
    frm_d1_q <= sync_q[S_FRM];
    frm_d2_q <= frm_d1_q;
    tgl_prev_q <= sync_q[S_TGL];
    clr_prev_q <= sync_q[S_CLR];
    output_load_strobe_n_prev_q <= sync_q[S_OUTPUT_LOAD_STROBE_N];
  end

  logic word_evt; // new word arrived
  logic frame_end; // sync rise, one cycle late
  logic clr_fall;
  logic output_load_strobe_n_fall;
  logic clamp_on;

  assign word_evt = sync_q[S_TGL] ^ tgl_prev_q;
  // extra delay lets a toggle resolved late still land before the commit
  assign frame_end = frm_d1_q && !frm_d2_q;
  assign clr_fall = clr_prev_q && !sync_q[S_CLR];
  assign output_load_strobe_n_fall = output_load_strobe_n_prev_q && !sync_q[S_OUTPUT_LOAD_STROBE_N];
  assign clamp_on = !sync_q[S_CLAMP];

  //////////////////////////////////////////////////////////////////////////////
  // staging: last complete word of the frame waits for the frame end
  logic [23:0] stg_q;
  logic stg_vld_q; // word staged this frame
  logic commit_q; // staged word offered to the fifo
  logic push_ready;

  // staging data, overwritten so that a chain keeps its last word
  always_ff @(posedge mclk)
  begin
    if (rst)
      stg_q <= WORD_RESET;
    else if (word_evt && !commit_q)
      stg_q <= xfer_q;
  end

  // commit offer; a full fifo holds it, later frames are then dropped
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stg_vld_q <= 1'b0;
      commit_q <= 1'b0;
    end
    else if (commit_q)
    begin
      if (push_ready)
      begin
        commit_q <= 1'b0;
        stg_vld_q <= 1'b0;
      end
    end
    else if (word_evt)
      stg_vld_q <= 1'b1; // arrival wins over the frame end, but is ignored while a commit is pending
    else if (frame_end && stg_vld_q)
      commit_q <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // fifo between the link and the register decoder
  logic pop_valid;
  logic pop_ready;
  logic [23:0] pop_data;
  ddslc_word_t cmd;

  ddslc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .in_valid(commit_q),
    .in_ready(push_ready),
    .in_data(stg_q),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // register writes stall while the outputs are clamped
  assign pop_ready = !clamp_on;
  assign cmd = pop_data;

  logic take; // a command is applied this cycle
  logic wr_data;
  logic hit_a;
  logic hit_b;

  assign take = pop_valid && pop_ready;
  assign wr_data = take && !cmd.rd && cmd.sel == SEL_DATA;
  assign hit_a = cmd.addr == ADDR_A || cmd.addr == ADDR_ALL;
  assign hit_b = cmd.addr == ADDR_B || cmd.addr == ADDR_ALL;

  //////////////////////////////////////////////////////////////////////////////
  // converter input and output registers
  ddslc_dac_t in_q; // input registers
  ddslc_dac_t dac_q; // converter registers
  ddslc_gp_t gp_q; // pin configuration

  // input registers always take a data write
  always_ff @(posedge mclk)
  begin
    if (rst)
      in_q <= '{a: ZERO_CODE, b: ZERO_CODE};
    else if (wr_data)
    begin
      if (hit_a)
        in_q.a <= cmd.data;
      if (hit_b)
        in_q.b <= cmd.data;
    end
  end

  // converter registers: clear, then strobe, then direct update
  always_ff @(posedge mclk)
  begin
    if (rst)
      dac_q <= '{a: ZERO_CODE, b: ZERO_CODE};
    else if (clr_fall)
      dac_q <= '{a: ZERO_CODE, b: ZERO_CODE};
    else if (output_load_strobe_n_fall)
      dac_q <= in_q;
    else if (wr_data && !sync_q[S_OUTPUT_LOAD_STROBE_N])
    begin
      if (hit_a)
        dac_q.a <= cmd.data;
      if (hit_b)
        dac_q.b <= cmd.data;
    end
  end

  // pin configuration write
  always_ff @(posedge mclk)
  begin
    if (rst)
      gp_q <= GP_RESET;
    else if (take && !cmd.rd && cmd.sel == SEL_FUNC)
      gp_q <= cmd.data[3:0];
  end

  // readback word, its valid flag cleared once the next frame has delivered a word
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rb_q <= WORD_RESET;
      rb_vld_q <= 1'b0;
    end
    else if (take && cmd.rd)
    begin
      rb_vld_q <= 1'b1;
      rb_q.rd <= cmd.rd;
      rb_q.spare <= 1'b0;
      rb_q.sel <= cmd.sel;
      rb_q.addr <= cmd.addr;
      if (cmd.sel == SEL_FUNC)
        rb_q.data <= {FUNC_PAD, sync_q[S_GP1], sync_q[S_GP0], gp_q};
      else if (cmd.addr == ADDR_B)
        rb_q.data <= dac_q.b;
      else
        rb_q.data <= dac_q.a;
    end
    else if (word_evt)
      rb_vld_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog-facing codes: zero while clamped, registers untouched
  always_ff @(posedge mclk)
  begin
    if (rst)
      dac_code <= '{a: ZERO_CODE, b: ZERO_CODE};
    else if (clamp_on)
      dac_code <= '{a: ZERO_CODE, b: ZERO_CODE};
    else
    begin
      dac_code.a <= to_straight(dac_q.a, sync_q[S_CODE]);
      dac_code.b <= to_straight(dac_q.b, sync_q[S_CODE]);
    end
  end

  // pin drivers come straight from the configuration flops
  assign gp_pin_zero_o = gp_q.out0;
  assign gp_pin_zero_oe = gp_q.oe0;
  assign gp_pin_zero_pu = !gp_q.oe0;
  assign gp_pin_one_o = gp_q.out1;
  assign gp_pin_one_oe = gp_q.oe1;
  assign gp_pin_one_pu = !gp_q.oe1;

  // reset output asserted while supply is bad or during our own reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      monitor_reset_out <= 1'b1;
    else
      monitor_reset_out <= !sync_q[S_SUP];
  end

endmodule : ddslc_top
`default_nettype wire

// ==== rtl/ddslc_pkg.sv ====
`default_nettype none
package ddslc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int WORD_W = 24; // one write frame, standalone
  localparam int CODE_W = 16; // converter code width
  localparam int FIFO_DEPTH = 4; // committed words waiting for the decoder
  localparam int SYNC_W = 9; // pins and the word toggle that cross into mclk

  // bit counter inside a frame
  localparam logic [4:0] BIT_FIRST = 5'h00;
  localparam logic [4:0] BIT_LAST = 5'h17; // 24th falling edge
  localparam logic [4:0] BIT_STEP = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // command word layout
  typedef struct packed {
    logic rd; // 1: readback request
    logic spare; // ignored
    logic [2:0] sel; // register group
    logic [2:0] addr; // channel address
    logic [15:0] data; // payload
  } ddslc_word_t;

  // register groups
  localparam logic [2:0] SEL_FUNC = 3'h0; // pin configuration
  localparam logic [2:0] SEL_DATA = 3'h2; // converter data
  // channel addresses
  localparam logic [2:0] ADDR_A = 3'h0;
  localparam logic [2:0] ADDR_B = 3'h1;
  localparam logic [2:0] ADDR_ALL = 3'h4;

  // pair of converter codes
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } ddslc_dac_t;

  // general-purpose pin configuration, low nibble of a function write
  typedef struct packed {
    logic oe1;
    logic out1;
    logic oe0;
    logic out0;
  } ddslc_gp_t;

  ////////////////////////////////////////////////////////////////////////////
  // reset and fixed values
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MSB_FLIP = 16'h8000;
  localparam logic [3:0] GP_RESET = 4'h0; // both pins inputs
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [9:0] FUNC_PAD = 10'h000;

  // positions in the synchroniser vector
  localparam int S_FRM = 0;
  localparam int S_TGL = 1;
  localparam int S_CLR = 2;
  localparam int S_OUTPUT_LOAD_STROBE_N = 3;
  localparam int S_CLAMP = 4;
  localparam int S_CODE = 5;
  localparam int S_SUP = 6;
  localparam int S_GP0 = 7;
  localparam int S_GP1 = 8;

endpackage : ddslc_pkg
`default_nettype wire

// ==== sim/ddslc_asserts.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// pin checker for ddslc_top
module ddslc_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic zero_clear_n,
  input wire logic output_load_strobe_n,
  input wire logic output_clamp_in,
  input wire logic coding_select,
  input wire logic supply_good,
  input wire logic gp_pin_zero_i,
  input wire logic gp_pin_zero_o,
  input wire logic gp_pin_zero_oe,
  input wire logic gp_pin_zero_pu,
  input wire logic gp_pin_one_i,
  input wire logic gp_pin_one_o,
  input wire logic gp_pin_one_oe,
  input wire logic gp_pin_one_pu,
  input wire logic monitor_reset_out,
  input wire ddslc_pkg::ddslc_dac_t dac_code
);
  import ddslc_pkg::*;

  logic [4:0] pins_q; // last pin levels
  logic [5:0] quiet_q; // cycles since an event that may move outputs
  logic cause; // frame end, strobe fall, clear fall, clamp or coding change
  assign cause = (frame_sync_n & ~pins_q[0]) | (pins_q[1] & ~output_load_strobe_n)
    | (pins_q[2] & ~zero_clear_n) | (pins_q[3] ^ output_clamp_in) | (pins_q[4] ^ coding_select);

  // edge memory
  always_ff @(posedge mclk)
    pins_q <= {coding_select, output_clamp_in, zero_clear_n, output_load_strobe_n, frame_sync_n};

  // saturating age, so a spurious change far from any cause is seen
  always_ff @(posedge mclk)
    if (rst || cause)
      quiet_q <= 6'h00;
    else if (quiet_q != 6'h3f)
      quiet_q <= quiet_q + 6'h01;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_rst_vals;
    disable iff (1'b0)
    rst |=> dac_code == '0 && !gp_pin_zero_oe && !gp_pin_one_oe && monitor_reset_out;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");
  property p_clear;
    $fell(zero_clear_n) |->
      ##[1:8] dac_code == {2{(output_clamp_in && !coding_select) ? MSB_FLIP : ZERO_CODE}};
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero codes");
  property p_clamp;
    !output_clamp_in [*5] |=> dac_code == '0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp did not zero outputs");
  property p_mon_bad;
    !supply_good [*6] |=> monitor_reset_out;
  endproperty
  a_mon_bad: assert property (p_mon_bad) else $error("reset out low on bad supply");
  property p_mon_good;
    supply_good [*6] |=> !monitor_reset_out;
  endproperty
  a_mon_good: assert property (p_mon_good) else $error("reset out high on good supply");
  property p_dac_cause;
    $changed(dac_code) |-> quiet_q < 6'h14;
  endproperty
  a_dac_cause: assert property (p_dac_cause) else $error("code moved with no cause");
  property p_gp_cause;
    $changed({gp_pin_zero_oe, gp_pin_one_oe, gp_pin_zero_o, gp_pin_one_o}) |-> quiet_q < 6'h14;
  endproperty
  a_gp_cause: assert property (p_gp_cause) else $error("pin setup moved outside a write");
  property p_pullup;
    (gp_pin_zero_pu ^ gp_pin_zero_oe) && (gp_pin_one_pu ^ gp_pin_one_oe);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not tied to input mode");
  property p_sout;
    $changed(serial_out_line) |-> $rose(shift_clk);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out moved off clock rise");

  // main scenarios
  c_frame_low: cover property (frame_sync_n && !pins_q[0] && !output_load_strobe_n);
  c_clear: cover property ($fell(zero_clear_n));
  c_gp_out: cover property ($rose(gp_pin_zero_oe));
endmodule : ddslc_asserts

bind ddslc_top ddslc_asserts i_chk (.*);
`default_nettype wire

// ==== sim/ddslc_host.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host serial port: msb first, clock parked high between frames
module ddslc_host (
  output logic shift_clk,
  output logic frame_sync_n,
  output logic serial_in_line,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [23:0] rx_q; // last 24 bits seen on the return line
  initial
  begin
    shift_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in_line = 1'b0;
    rx_q = 24'h000000;
  end

  // hold high sends the edges with no frame, for the ignore case
  task automatic send(input logic [23:0] w, input int n, input logic hold);
    frame_sync_n = hold;
    #13.2;
    for (int i = 0; i < n; i++)
    begin
      serial_in_line = w[23 - i]; // set 4 ns ahead, held to the next bit
      #4 shift_clk = 1'b0; // sampling edge
      #13 shift_clk = 1'b1; // 34 ns period stays under 30 MHz
      #1 rx_q = {rx_q[22:0], serial_out_line}; // return bit after the rise
      #16;
    end
    frame_sync_n = 1'b1; // raised after the last falling edge
    serial_in_line = ~serial_in_line; // released line shows no stale bit
    #120;
  endtask : send
endmodule : ddslc_host
`default_nettype wire

// ==== sim/ddslc_top_tb.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// random writes through the host model, checks at the pins
module ddslc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ddslc_pkg::*;

  logic mclk = 1'b0;
  logic rst, zero_clear_n, output_load_strobe_n, output_clamp_in, coding_select;
  logic supply_good, ext0, ext1, serial_out_line, monitor_reset_out;
  logic shift_clk, frame_sync_n, serial_in_line;
  logic gp_pin_zero_i, gp_pin_zero_o, gp_pin_zero_oe, gp_pin_zero_pu;
  logic gp_pin_one_i, gp_pin_one_o, gp_pin_one_oe, gp_pin_one_pu;
  ddslc_dac_t dac_code;
  logic [15:0] in_a, in_b, cv_a, cv_b; // expected input and converter registers
  logic [31:0] seed; // xorshift state
  logic [2:0] adr [3] = '{ADDR_A, ADDR_B, ADDR_ALL};
  logic [3:0] cfg [3] = '{4'ha, 4'hf, 4'h5}; // outputs low, outputs high, inputs
  int failures, comparisons;

  // pin level: the device drives it, else the outside does
  assign gp_pin_zero_i = gp_pin_zero_oe ? gp_pin_zero_o : ext0;
  assign gp_pin_one_i = gp_pin_one_oe ? gp_pin_one_o : ext1;
  ddslc_top i_dut (.*);
  ddslc_host i_host (.*);
  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  // outputs as the pins should show them, clamp and coding applied
  function automatic logic [31:0] exp_dac();
    return output_clamp_in ? {cv_a ^ {~coding_select, 15'h0}, cv_b ^ {~coding_select, 15'h0}} : '0;
  endfunction : exp_dac
  function automatic logic lvl(input logic [1:0] c, input logic e);
    return c[1] ? c[0] : e;
  endfunction : lvl
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // one 24-bit write, model updated alongside
  task automatic wr(input logic [2:0] sel, input logic [2:0] addr, input logic [15:0] d);
    logic ha = sel == SEL_DATA && addr != ADDR_B;
    logic hb = sel == SEL_DATA && addr != ADDR_A;
    i_host.send({2'b00, sel, addr, d}, 24, 1'b0);
    in_a = ha ? d : in_a;
    in_b = hb ? d : in_b;
    cv_a = ha && !output_load_strobe_n ? d : cv_a;
    cv_b = hb && !output_load_strobe_n ? d : cv_b;
    cyc(20);
  endtask : wr
  task automatic ld_pulse();
    output_load_strobe_n <= 1'b0;
    cv_a = in_a;
    cv_b = in_b;
    cyc(4);
    output_load_strobe_n <= 1'b1;
    cyc(10);
  endtask : ld_pulse
  task automatic do_reset();
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    {in_a, in_b, cv_a, cv_b} = '0;
    cyc(4);
    chk_word(dac_code, exp_dac());
    chk_bit(gp_pin_zero_pu, 1'b1);
  endtask : do_reset
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    // reset rises later by nonblocking, so the link flops see its edge
    {rst, zero_clear_n, output_clamp_in, coding_select, supply_good} = 5'h0f;
    output_load_strobe_n = 1'b0; // driven from time zero
    {ext0, ext1} = 2'h2;
    seed = 32'h0001510c;
    failures = 0;
    comparisons = 0;
    do_reset();
    for (int k = 0; k < 6; k++)
    begin
      coding_select <= k[0]; // both codings, all addresses
      wr(SEL_DATA, adr[k % 3], k < 2 ? {16{k[0]}} : rnd());
      chk_word(dac_code, exp_dac());
    end
    $display("test direct writes done");
    i_host.send({8'h10, rnd()}, 24, 1'b1); // edges with sync high
    i_host.send({8'h10, rnd()}, 12, 1'b0); // short frame
    cyc(20);
    chk_word(dac_code, exp_dac());
    $display("test ignored edges done");
    output_load_strobe_n <= 1'b1;
    wr(SEL_DATA, ADDR_A, rnd());
    wr(SEL_DATA, ADDR_B, rnd());
    chk_word(dac_code, exp_dac()); // outputs held
    ld_pulse();
    chk_word(dac_code, exp_dac());
    wr(SEL_DATA, ADDR_A, rnd());
    zero_clear_n <= 1'b0;
    {cv_a, cv_b} = '0;
    cyc(4);
    zero_clear_n <= 1'b1;
    cyc(10);
    chk_word(dac_code, exp_dac());
    ld_pulse();
    chk_word(dac_code, exp_dac()); // input registers survive the clear
    $display("test strobe and clear done");
    output_clamp_in <= 1'b0;
    cyc(10);
    chk_word(dac_code, exp_dac());
    output_clamp_in <= 1'b1;
    cyc(10);
    chk_word(dac_code, exp_dac()); // codes kept
    $display("test clamp done");
    for (int k = 0; k < 3; k++)
    begin
      {ext0, ext1} <= 2'(rnd());
      wr(SEL_FUNC, ADDR_A, {12'h000, cfg[k]});
      chk_bit(gp_pin_zero_oe, cfg[k][1]);
      chk_bit(gp_pin_zero_o, cfg[k][0]);
      chk_bit(gp_pin_one_pu, !cfg[k][3]);
      chk_bit(gp_pin_one_oe, cfg[k][3]);
      chk_bit(gp_pin_one_o, cfg[k][2]);
      i_host.send({2'b10, SEL_FUNC, ADDR_A, 16'h0}, 24, 1'b0);
      i_host.send({2'b10, SEL_FUNC, ADDR_A, 16'h0}, 24, 1'b0);
      chk_word(i_host.rx_q[15:0], {10'h0, lvl(cfg[k][3:2], ext1), lvl(cfg[k][1:0], ext0), cfg[k]});
      cyc(2);
    end
    // converter readback: whole word comes back, header included
    i_host.send({2'b10, SEL_DATA, ADDR_B, 16'h0}, 24, 1'b0);
    i_host.send({2'b10, SEL_DATA, ADDR_B, 16'h0}, 24, 1'b0);
    chk_word(i_host.rx_q, {2'b10, SEL_DATA, ADDR_B, cv_b});
    $display("test pins done");
    supply_good <= 1'b0;
    cyc(10);
    chk_bit(monitor_reset_out, 1'b1);
    supply_good <= 1'b1;
    cyc(10);
    chk_bit(monitor_reset_out, 1'b0);
    do_reset();
    $display("test monitor and reset done");
    test_done();
  end

  // 22 frames, most near 1 us each; far longer means a hang
  initial
  begin
    #200us;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
endmodule : ddslc_top_tb
`default_nettype wire
